// File: logic/pcm_tsa_pkg.sv
// Purpose: shared constants and state type for the pcm highway slot assigner
// Assumes: bit clock and frame pulse come from the host, sampled by clk at 200 MHz
// Notes: all counts are in clk cycles unless named otherwise
package pcm_tsa_pkg;

  localparam int NUM_CH = 2;
  localparam int SLOT_W = 7;
  localparam int OFS_W = 3;
  localparam int BITCNT_W = 11;
  localparam int WORD_W = 32;
  localparam int IDX_W = 5;

  // fastest documented highway rate against the local clock
  localparam int CLK_KHZ = 200000;
  localparam int MAX_BIT_CLK_KHZ = 8192;
  // whole clk cycles in one bit clock period, rounded down
  localparam int BIT_PERIOD_CYC = CLK_KHZ / MAX_BIT_CLK_KHZ;
  // rising edges closer than this mean the bit clock is out of range
  localparam logic [7:0] MIN_RISE_GAP = 8'(BIT_PERIOD_CYC / 2);
  // rise gap counter parks here until the first bit clock rise
  localparam logic [7:0] RISE_GAP_RESET = 8'hFF;

  localparam logic [BITCNT_W-1:0] BITCNT_RESET = 11'h000;
  localparam logic [BITCNT_W-1:0] FRAMEBITS_RESET = 11'h000;

  typedef struct packed {
    logic bitClkPrev;
    logic fsPrev;
    logic framed;
    logic [BITCNT_W-1:0] bitCount;
    logic [BITCNT_W-1:0] frameBits;
    logic [NUM_CH-1:0][WORD_W-1:0] txWord;
    logic [NUM_CH-1:0][WORD_W-1:0] rxShift;
    logic [NUM_CH-1:0][WORD_W-1:0] rxWord;
    logic rxValid;
    logic txTake;
    logic txPin;
    logic txOe;
    logic pendBit;
    logic pendOe;
    logic [NUM_CH-1:0] rxHit;
    logic [NUM_CH-1:0][IDX_W-1:0] rxIdx;
  } state_t;

  localparam state_t STATE_RESET = '{
    bitClkPrev: 1'b0, fsPrev: 1'b0, framed: 1'b0,
    bitCount: BITCNT_RESET, frameBits: FRAMEBITS_RESET,
    txWord: '0, rxShift: '0, rxWord: '0,
    rxValid: 1'b0, txTake: 1'b0, txPin: 1'b0, txOe: 1'b0,
    pendBit: 1'b0, pendOe: 1'b0, rxHit: '0, rxIdx: '0
  };

endpackage

// File: logic/pin_sync2.sv
// Purpose: two-flop synchroniser for pins from outside the clk domain
// Assumes: each bit is an independent level
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module pin_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] held;
  } sync_t;

  sync_t st;
  sync_t next_st;

  // shift one stage per clock
  always_comb begin
    next_st.meta = d;
    next_st.held = st.meta;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.held;

endmodule

// File: logic/pcm_highway_slot_assigner.sv
// Purpose: time slot assigner and pcm highway port for two voice channels
// Assumes: host drives bit clock and frame pulse; compressor and expander are on clk
// Notes: bit clock is oversampled by clk, so highway timing is quantised to 5 ns
// Operation
// - host bit clock is 1.024 to 8.192 MHz, frame pulse recurs at 8 kHz.
// - highway port only runs while the host interface select pin is high.
// - drive outgoing samples on tx pin, capture incoming samples from rx pin.
// - compressed sample uses one byte slot; linear uses two adjacent slots.
// - each frame pulse starts a frame; all slot positions count from it.
// - wideband exchanges two evenly spaced sets of slots per frame.
// - separate 3-bit transmit and receive offsets shift slots by 0 to 7 bits.
// - both offsets are global, shared by every channel.
// - each channel has its own transmit slot and its own receive slot.
// - transmit data launches on rising or falling bit clock edge, selectable.
// - transmit slot number is 7 bits, up to 128 byte slots.
// - every sample byte goes out most significant bit first.
// - wideband uses twice the slots of narrowband linear per channel.
// - outgoing compressor codes are serialised into the channel's transmit slot.
// - receive slot is 7 bits; received bytes, msb first, go to the expander.
`timescale 1ns/1ps
module pcm_highway_slot_assigner (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pcmBitClkPin,
  input wire logic framePulse,
  input wire logic highwayRxPin,
  input wire logic hostIfSelectPin,
  input wire logic txOnRising,
  input wire logic [2:0] txClkOffset,
  input wire logic [2:0] rxClkOffset,
  input wire logic [1:0][6:0] transmitSlotNumber,
  input wire logic [1:0][6:0] receiveSlotNumber,
  input wire logic [1:0] linearMode,
  input wire logic [1:0] widebandMode,
  input wire logic [1:0][31:0] txSample,
  output logic txSampleTake,
  output logic [1:0][31:0] rxSample,
  output logic rxSampleValid,
  output logic highwayTxPin,
  output logic highwayTxOe
);

  // returns {hit, set, byte} for a slot against one channel's base slot
  function automatic logic [2:0] slot_match(
    input logic [6:0] slot,
    input logic [6:0] base,
    input logic lin,
    input logic wb,
    input logic [6:0] half
  );
    logic [6:0] d1;
    logic [6:0] d2;
    logic [2:0] res;
    d1 = slot - base;
    d2 = slot - base - half;
    res = 3'h0;
    if (wb && d1 < 7'h02) begin
      res = {2'b10, d1[0]};
    end else if (wb && d2 < 7'h02) begin
      res = {2'b11, d2[0]};
    end else if (!wb && lin && d1 < 7'h02) begin
      res = {2'b10, d1[0]};
    end else if (d1 == 7'h00) begin
      res = 3'h4;
    end
    return res;
  endfunction

  pcm_tsa_pkg::state_t st;
  pcm_tsa_pkg::state_t next_st;
  logic bitClkSync;
  logic fsSync;
  logic rxSync;
  logic selSync;
  logic bitRise;
  logic bitFall;
  logic fsStart;

  // every highway pin crosses two flops before use
  pin_sync2 #(.W(4)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d({pcmBitClkPin, framePulse, highwayRxPin, hostIfSelectPin}),
    .q({bitClkSync, fsSync, rxSync, selSync})
  );

  // edges of the oversampled bit clock
  assign bitRise = bitClkSync & ~st.bitClkPrev;
  assign bitFall = ~bitClkSync & st.bitClkPrev;
  assign fsStart = bitRise & fsSync & ~st.fsPrev;

  // next state: frame counting, slot matching, shifting
  always_comb begin
    logic [pcm_tsa_pkg::BITCNT_W-1:0] txPos;
    logic [pcm_tsa_pkg::BITCNT_W-1:0] rxPos;
    logic [6:0] half;
    logic txOk;
    logic rxOk;
    logic [2:0] m;
    txPos = '0;
    rxPos = '0;
    half = 7'h00;
    txOk = 1'b0;
    rxOk = 1'b0;
    m = 3'h0;
    next_st = st;
    next_st.txTake = 1'b0;
    next_st.rxValid = 1'b0;
    next_st.bitClkPrev = bitClkSync;
    if (bitRise) begin
      next_st.fsPrev = fsSync;
      if (fsStart) begin
        next_st.bitCount = pcm_tsa_pkg::BITCNT_RESET;
        next_st.frameBits = st.bitCount + 11'h001;
        next_st.framed = 1'b1;
        next_st.txWord = txSample;
        next_st.rxWord = st.rxShift;
        next_st.rxValid = 1'b1;
        next_st.txTake = 1'b1;
      end else begin
        next_st.bitCount = st.bitCount + 11'h001;
      end
      // second wideband set sits half a frame later
      half = next_st.frameBits[10:4];
      // one offset pair for the whole device
      txPos = next_st.bitCount - {8'h00, txClkOffset};
      rxPos = next_st.bitCount - {8'h00, rxClkOffset};
      txOk = next_st.framed && next_st.bitCount >= {8'h00, txClkOffset};
      rxOk = next_st.framed && next_st.bitCount >= {8'h00, rxClkOffset};
      next_st.pendOe = 1'b0;
      next_st.pendBit = 1'b0;
      next_st.rxHit = '0;
      // descending so channel 0 wins a clash the host should never make
      for (int c = pcm_tsa_pkg::NUM_CH - 1; c >= 0; c--) begin
        m = slot_match(txPos[9:3], transmitSlotNumber[c], linearMode[c],
          widebandMode[c], half);
        if (txOk && m[2]) begin
          next_st.pendOe = 1'b1;
          next_st.pendBit = next_st.txWord[c][~{m[1:0], txPos[2:0]}];
        end
        m = slot_match(rxPos[9:3], receiveSlotNumber[c], linearMode[c],
          widebandMode[c], half);
        if (rxOk && m[2]) begin
          next_st.rxHit[c] = 1'b1;
          next_st.rxIdx[c] = ~{m[1:0], rxPos[2:0]};
        end
      end
      if (txOnRising) begin
        next_st.txPin = next_st.pendBit;
        next_st.txOe = next_st.pendOe;
      end
    end
    if (bitFall) begin
      if (!txOnRising) begin
        next_st.txPin = st.pendBit;
        next_st.txOe = st.pendOe;
      end
      // sample mid bit, half a period after the position starts
      for (int c = 0; c < pcm_tsa_pkg::NUM_CH; c++) begin
        if (st.rxHit[c]) begin
          next_st.rxShift[c][st.rxIdx[c]] = rxSync;
        end
      end
    end
    // the other host interface owns the pins when select is low
    if (!selSync) begin
      next_st.txOe = 1'b0;
      next_st.pendOe = 1'b0;
      next_st.rxHit = '0;
      next_st.framed = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= pcm_tsa_pkg::STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign highwayTxPin = st.txPin;
  assign highwayTxOe = st.txOe;
  assign txSampleTake = st.txTake;
  assign rxSample = st.rxWord;
  assign rxSampleValid = st.rxValid;

  // clk cycles since the last bit clock rise, helper for checks only
  logic [7:0] riseGap;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      riseGap <= pcm_tsa_pkg::RISE_GAP_RESET;
    end else if (bitRise) begin
      riseGap <= 8'h01;
    end else if (riseGap != pcm_tsa_pkg::RISE_GAP_RESET) begin
      riseGap <= riseGap + 8'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_OE_NEEDS_SELECT: assert property (
    highwayTxOe |-> $past(selSync) && st.framed)
    else $error("tx driven while host port deselected");

  AST_FRAME_RESTART: assert property (
    fsStart |=> st.bitCount == 11'h000 && st.txTake && st.rxValid)
    else $error("frame pulse did not restart the frame");

  AST_COUNT_STEP: assert property (
    bitRise && !fsStart |=> st.bitCount == $past(st.bitCount) + 11'h001)
    else $error("bit counter did not step on bit clock rise");

  AST_TAKE_ONCE: assert property (
    st.txTake |=> !st.txTake [*2])
    else $error("sample take lasted more than one cycle");

  AST_RX_LOAD: assert property (
    fsStart |=> st.rxWord == $past(st.rxShift) && st.txWord == $past(txSample))
    else $error("frame words not handed over at frame start");

  AST_TX_EDGE: assert property (
    $changed(highwayTxPin) |-> ($past(txOnRising) ? $past(bitRise) : $past(bitFall))
      || $past(txOnRising, 1) != $past(txOnRising, 2))
    else $error("tx data changed off the selected edge");

  AST_OE_FOLLOWS_SLOT: assert property (
    bitFall && !txOnRising && selSync |=> highwayTxOe == $past(st.pendOe))
    else $error("tx enable does not follow slot match");

  AST_RX_HOLD: assert property (
    !bitFall |=> st.rxShift == $past(st.rxShift))
    else $error("rx shift changed outside a sampling edge");

  AST_RISE_SPACING: assert property (
    bitRise |-> riseGap >= pcm_tsa_pkg::MIN_RISE_GAP)
    else $error("bit clock faster than the highest highway rate");

endmodule

// File: dv/pcm_host_model.sv
// Purpose: host pcm port driving bit clock, frame pulse and rx data
// Assumes: 125 ns bit clock, short frame of FRAME_BITS bits
// Notes: frame is shortened from 8 kHz to keep the run brief
`timescale 1ns/1ps
module pcm_host_model #(
  parameter int FRAME_BITS = 128
) (
  input wire logic txPin,
  input wire logic txOe,
  input wire logic txOnRising,
  input wire logic [127:0] rxPattern,
  output logic pcmBitClk,
  output logic framePulse,
  output logic rxPin,
  output logic [127:0] frameBit,
  output logic [127:0] frameOe,
  output int frameCount
);
  logic [127:0] curBit;
  logic [127:0] curOe;
  int k;
  // free-running clock; tx sampled on the edge opposite the launch
  initial begin
    {pcmBitClk, framePulse, rxPin} = 3'h0;
    {frameBit, frameOe, curBit, curOe} = '0;
    frameCount = 0;
    k = FRAME_BITS - 1;
    // keep pin edges off clk edges so the synchroniser never races them
    #1.25;
    forever begin
      #62.5 pcmBitClk = 1'b1;
      if (!txOnRising) begin
        curBit[k] = txPin;
        curOe[k] = txOe;
      end
      k = (k + 1) % FRAME_BITS;
      if (k == 0) begin
        frameBit = curBit;
        frameOe = curOe;
        frameCount++;
      end
      rxPin = rxPattern[k];
      #62.5 pcmBitClk = 1'b0;
      if (txOnRising) begin
        curBit[k] = txPin;
        curOe[k] = txOe;
      end
      framePulse = (k == FRAME_BITS - 1);
    end
  end
endmodule

// File: dv/tb.sv
// Purpose: self-checking bench for the pcm highway slot assigner
// Assumes: host model frames of 128 bits, so wideband half is 8 slots
// Notes: first frame after a change is skipped, it holds mixed settings
`timescale 1ns/1ps
module tb;
  localparam logic [127:0] RX_PAT = 128'hC3A50F96_5E21B7D4_83F60A1C_E94D2B7F;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic bitClk, fp, rxPin, take, rxValid, txPin, txOe;
  logic sel = 1'b1;
  logic txRise = 1'b1;
  logic [2:0] txOfs = 3'h0;
  logic [2:0] rxOfs = 3'h0;
  logic [1:0][6:0] txSlot = '0;
  logic [1:0][6:0] rxSlot = '0;
  logic [1:0] lin = 2'h0;
  logic [1:0] wb = 2'h0;
  logic [1:0][31:0] txWord = '0;
  logic [1:0][31:0] rxWord;
  logic [127:0] capBit, capOe, expBit, expOe;
  int frames;
  int errCount = 0;
  int checked = 0;
  int takeCount = 0;
  int validCount = 0;

  pcm_highway_slot_assigner u_dut (.clk(clk), .sys_rst(sys_rst), .pcmBitClkPin(bitClk),
    .framePulse(fp), .highwayRxPin(rxPin), .hostIfSelectPin(sel), .txOnRising(txRise),
    .txClkOffset(txOfs), .rxClkOffset(rxOfs), .transmitSlotNumber(txSlot),
    .receiveSlotNumber(rxSlot), .linearMode(lin), .widebandMode(wb), .txSample(txWord),
    .txSampleTake(take), .rxSample(rxWord), .rxSampleValid(rxValid),
    .highwayTxPin(txPin), .highwayTxOe(txOe));
  pcm_host_model u_host (.txPin(txPin), .txOe(txOe), .txOnRising(txRise),
    .rxPattern(RX_PAT), .pcmBitClk(bitClk), .framePulse(fp), .rxPin(rxPin),
    .frameBit(capBit), .frameOe(capOe), .frameCount(frames));

  // 200 MHz system clock
  always #2.5 clk = ~clk;

  // count one-cycle handover pulses mid cycle, where they are settled
  always @(negedge clk) begin
    if (take === 1'b1) takeCount++;
    if (rxValid === 1'b1) validCount++;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, errCount);
    if (errCount == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic ok, input string what);
    checked++;
    if (ok !== 1'b1) begin
      errCount++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask

  // bounded wait for whole frames, then let rx update land
  task automatic wait_frames(input int n);
    int start;
    int i;
    start = frames;
    for (i = 0; i < 5000 * n && frames < start + n; i++) @(negedge clk);
    if (frames < start + n) begin
      check(1'b0, "frame timeout");
      report_and_stop();
    end
    repeat (10) @(negedge clk);
    expBit = '0;
    expOe = '0;
  endtask

  // expected byte on the wire, msb first, shifted by the offset
  task automatic place(input int slot, input int ofs, input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      expBit[8 * slot + ofs + i] = b[7 - i];
      expOe[8 * slot + ofs + i] = 1'b1;
    end
  endtask

  function automatic logic [7:0] rx_byte(input int slot, input int ofs);
    for (int i = 0; i < 8; i++) rx_byte[7 - i] = RX_PAT[8 * slot + ofs + i];
  endfunction

  task automatic tx_compare();
    check(capOe === expOe, "tx enable map");
    check((capBit & expOe) === (expBit & expOe), "tx bits");
  endtask

  task automatic t_narrow();
    @(negedge clk);
    txSlot = {7'h05, 7'h02};
    rxSlot = {7'h06, 7'h03};
    txWord = {32'h3C000000, 32'h96000000};
    wait_frames(3);
    place(2, 0, 8'h96);
    place(5, 0, 8'h3C);
    tx_compare();
    check(rxWord[0][31:24] === rx_byte(3, 0), "rx ch0");
    check(rxWord[1][31:24] === rx_byte(6, 0), "rx ch1");
    $display("narrow test done");
  endtask

  task automatic t_linear();
    int t0;
    int v0;
    @(negedge clk);
    t0 = takeCount;
    v0 = validCount;
    {txRise, txOfs, rxOfs, lin} = {1'b0, 3'h3, 3'h7, 2'h3};
    txSlot = {7'h09, 7'h01};
    rxSlot = {7'h0C, 7'h04};
    txWord = {32'hC46E0000, 32'h81370000};
    wait_frames(3);
    place(1, 3, 8'h81);
    place(2, 3, 8'h37);
    place(9, 3, 8'hC4);
    place(10, 3, 8'h6E);
    tx_compare();
    check(takeCount - t0 == 3, "sample take pulses per frame");
    check(validCount - v0 == 3, "rx valid pulses per frame");
    check(rxWord[0][31:16] === {rx_byte(4, 7), rx_byte(5, 7)}, "rx lin ch0");
    check(rxWord[1][31:16] === {rx_byte(12, 7), rx_byte(13, 7)}, "rx lin ch1");
    $display("linear test done");
  endtask

  task automatic t_wide();
    @(negedge clk);
    {txRise, txOfs, rxOfs, lin, wb} = {1'b1, 3'h1, 3'h2, 2'h0, 2'h1};
    txSlot = {7'h06, 7'h03};
    rxSlot = {7'h07, 7'h04};
    txWord = {32'h5A000000, 32'hE1724BD8};
    wait_frames(3);
    place(3, 1, 8'hE1);
    place(4, 1, 8'h72);
    place(11, 1, 8'h4B);
    place(12, 1, 8'hD8);
    place(6, 1, 8'h5A);
    tx_compare();
    check(rxWord[0] === {rx_byte(4, 2), rx_byte(5, 2), rx_byte(12, 2), rx_byte(13, 2)},
      "rx wide ch0");
    check(rxWord[1][31:24] === rx_byte(7, 2), "rx ch1 beside wide");
    $display("wideband test done");
  endtask

  task automatic t_deselect();
    @(negedge clk);
    sel = 1'b0;
    wait_frames(2);
    check(capOe === 128'h0, "tx driven while deselected");
    $display("deselect test done");
  endtask

  // main sequence
  initial begin
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    t_narrow();
    t_linear();
    t_wide();
    t_deselect();
    report_and_stop();
  end
endmodule
